/* rtl/prom_prog_regs.vh */
/*
 Timing counts and geometry constants for the fuse PROM read/program controller.
 Assumes a 250 MHz system clock (4 ns period).
*/
`ifndef PROM_PROG_REGS_VH
`define PROM_PROG_REGS_VH

`define CLK_PERIOD_PS 4000
`define ADDR_W 11
`define DATA_W 4
`define BIT_SEL_W 2
// Pulse width 7.5 us
`define PULSE_NS 7500
`define PULSE_CYC ((`PULSE_NS * 1000) / `CLK_PERIOD_PS)
// Sense delay after trailing pulse edge 0.7 us min
`define SENSE_DLY_NS 700
`define SENSE_DLY_CYC ((`SENSE_DLY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Sense interruption around address change 10 us min
`define ADDR_GUARD_NS 10000
`define ADDR_GUARD_CYC ((`ADDR_GUARD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Pulse spacing for 70 % duty ceiling (off time kept well above 30 %)
`define PULSE_GAP_CYC (`PULSE_CYC / 2)
// Sense settle before comparing output
`define SENSE_SETTLE_CYC 16
`define EXTRA_N 4
`define EXTRA_S 1
`define MAX_PULSES_S 10000
// Read access settle, covers address access 60 ns
`define READ_WAIT_NS 60
`define READ_WAIT_CYC ((`READ_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Extra read wait covering the data pin synchroniser
`define RD_SYNC_CYC 4
`define CNT_W 16

`endif

/* rtl/prom_timer.v */
/*
 Down-counting delay timer with load and one-cycle done pulse.
 Assumes loads come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "prom_prog_regs.vh"
module prom_timer
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Control
    input wire i_load,
    input wire [`CNT_W-1:0] i_count,
    // Status
    output reg o_done
);
    reg [`CNT_W-1:0] cnt_r;
    reg run_r;

    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_r <= 16'h0000;
            run_r <= 1'b0;
            o_done <= 1'b0;
        end
        else if (i_load)
        begin
            cnt_r <= i_count;
            run_r <= 1'b1;
            o_done <= 1'b0;
        end
        else if (run_r)
        begin
            if (cnt_r <= 16'h0001)
            begin
                run_r <= 1'b0;
                o_done <= 1'b1;
            end
            else
            begin
                cnt_r <= cnt_r - 16'h0001;
                o_done <= 1'b0;
            end
        end
        else
        begin
            o_done <= 1'b0;
        end
    end
endmodule // prom_timer

/* rtl/prom_prog_ctrl.v */
/*
 Host-side controller for a 2048 x 4 fuse PROM: reads words and programs single bits
 by pulse trains with sensing and extra pulses.
 Assumes external drivers turn o_PULSE/o_SENSE into programming and sense currents,
 and a comparator returns the sensed level on I_SENSE_HI (asynchronous).
*/
// Notes on behaviour
// - Place target address on address pins before any programming current.
// - Keep chip enable high throughout pulses and sensing.
// - Pulse chosen output until sensing shows one, then add extra pulses.
// - Extra pulses: four for N-series, one for S-series.
// - Wait minimum delay after each pulse trailing edge before sensing.
// - Sense current off for minimum interval before and after address change.
// - S-series: never exceed the maximum pulse count per bit.
// - Program only one output bit at a time.
`timescale 1ns/1ns
`include "prom_prog_regs.vh"
module prom_prog_ctrl
(
    // Clock and reset
    input wire I_SYS_CLK,
    input wire I_SYS_RST,
    // User command port
    input wire i_READ_REQ,
    input wire i_PROG_REQ,
    input wire i_S_SERIES,
    input wire [`ADDR_W-1:0] i_ADDR,
    input wire [`BIT_SEL_W-1:0] i_BIT_SEL,
    input wire [`CNT_W-1:0] i_MAX_PULSES_N,
    output reg o_BUSY,
    output reg o_DONE,
    output reg o_FAIL,
    output reg [`DATA_W-1:0] o_RD_DATA,
    // Device pins
    output reg [`ADDR_W-1:0] o_PROM_ADDR,
    output reg o_PROM_CE_N,
    input wire [`DATA_W-1:0] i_PROM_DATA,
    // Programming drivers
    output reg [`DATA_W-1:0] o_PULSE,
    output reg [`DATA_W-1:0] o_SENSE,
    input wire I_SENSE_HI
);
    localparam S_IDLE = 4'h0;
    localparam S_RD_WAIT = 4'h1;
    localparam S_ADDR_PRE = 4'h2;
    localparam S_PULSE = 4'h3;
    localparam S_DELAY = 4'h4;
    localparam S_SENSE = 4'h5;
    localparam S_GAP = 4'h6;
    localparam S_POST = 4'h7;
    localparam [31:0] RD_WAIT_32 = `READ_WAIT_CYC + `RD_SYNC_CYC;
    localparam [31:0] GUARD_32 = `ADDR_GUARD_CYC;
    localparam [31:0] PULSE_32 = `PULSE_CYC;
    localparam [31:0] SDLY_32 = `SENSE_DLY_CYC;
    localparam [31:0] GAP_32 = `PULSE_GAP_CYC;
    localparam [31:0] SETTLE_32 = `SENSE_SETTLE_CYC;
    localparam [31:0] LIMIT_S_32 = `MAX_PULSES_S;
    localparam [31:0] EXTRA_N_32 = `EXTRA_N;
    localparam [31:0] EXTRA_S_32 = `EXTRA_S;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [2:0] sense_sync_r;
    reg [`DATA_W-1:0] data_sync1_r;
    reg [`DATA_W-1:0] data_sync2_r;
    reg [`DATA_W-1:0] data_sync3_r;
    reg [`DATA_W-1:0] data_ok_r;
    reg sense_hi_r;
    reg [`CNT_W-1:0] pulses_r;
    reg [2:0] extra_r;
    reg extra_mode_r;
    reg s_series_r;
    reg [`BIT_SEL_W-1:0] bit_r;
    reg [`CNT_W-1:0] limit_r;
    reg tmr_load_r;
    reg [`CNT_W-1:0] tmr_count_r;
    wire tmr_done;
    wire [`DATA_W-1:0] bit_mask;

    assign bit_mask = 4'h1 << bit_r;

    prom_timer u_timer
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_load(tmr_load_r),
        .i_count(tmr_count_r),
        .o_done(tmr_done)
    );

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Change counts once second and third stages agree
    always @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            sense_sync_r <= 3'h0;
            sense_hi_r <= 1'b0;
            data_sync1_r <= 4'h0;
            data_sync2_r <= 4'h0;
            data_sync3_r <= 4'h0;
            data_ok_r <= 4'h0;
        end
        else
        begin
            sense_sync_r <= {sense_sync_r[1:0], I_SENSE_HI};
            if (sense_sync_r[1] == sense_sync_r[2])
                sense_hi_r <= sense_sync_r[2];
            data_sync1_r <= i_PROM_DATA;
            data_sync2_r <= data_sync1_r;
            data_sync3_r <= data_sync2_r;
            if (data_sync2_r == data_sync3_r)
                data_ok_r <= data_sync3_r;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (i_READ_REQ)
                    state_nxt = S_RD_WAIT;
                else if (i_PROG_REQ)
                    state_nxt = S_ADDR_PRE;
            S_RD_WAIT:
                if (tmr_done)
                    state_nxt = S_IDLE;
            S_ADDR_PRE:
                if (tmr_done)
                    state_nxt = S_PULSE;
            S_PULSE:
                if (tmr_done)
                    state_nxt = S_DELAY;
            S_DELAY:
                if (tmr_done)
                    state_nxt = extra_mode_r ? S_GAP : S_SENSE;
            S_SENSE:
                if (tmr_done)
                    state_nxt = S_GAP;
            S_GAP:
                if (tmr_done)
                    state_nxt = S_PULSE;
            S_POST:
                if (tmr_done)
                    state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            state_r <= S_IDLE;
            o_BUSY <= 1'b0;
            o_DONE <= 1'b0;
            o_FAIL <= 1'b0;
            o_RD_DATA <= 4'h0;
            o_PROM_ADDR <= 11'h000;
            o_PROM_CE_N <= 1'b1;
            o_PULSE <= 4'h0;
            o_SENSE <= 4'h0;
            pulses_r <= 16'h0000;
            extra_r <= 3'h0;
            extra_mode_r <= 1'b0;
            s_series_r <= 1'b0;
            bit_r <= 2'h0;
            limit_r <= 16'h0000;
            tmr_load_r <= 1'b0;
            tmr_count_r <= 16'h0000;
        end
        else
        begin
            tmr_load_r <= 1'b0;
            o_DONE <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    o_PULSE <= 4'h0;
                    o_SENSE <= 4'h0;
                    if (i_READ_REQ)
                    begin
                        o_PROM_ADDR <= i_ADDR;
                        o_PROM_CE_N <= 1'b0;
                        o_BUSY <= 1'b1;
                        tmr_load_r <= 1'b1;
                        tmr_count_r <= RD_WAIT_32[`CNT_W-1:0];
                    end
                    else if (i_PROG_REQ)
                    begin
                        // Address and deselect first, no current yet
                        o_PROM_ADDR <= i_ADDR;
                        o_PROM_CE_N <= 1'b1;
                        o_BUSY <= 1'b1;
                        o_FAIL <= 1'b0;
                        bit_r <= i_BIT_SEL;
                        s_series_r <= i_S_SERIES;
                        limit_r <= i_S_SERIES ? LIMIT_S_32[`CNT_W-1:0] : i_MAX_PULSES_N;
                        pulses_r <= 16'h0000;
                        extra_mode_r <= 1'b0;
                        extra_r <= 3'h0;
                        tmr_load_r <= 1'b1;
                        tmr_count_r <= GUARD_32[`CNT_W-1:0];
                    end
                end
                S_RD_WAIT:
                    if (tmr_done)
                    begin
                        o_RD_DATA <= data_ok_r;
                        o_PROM_CE_N <= 1'b1;
                        o_BUSY <= 1'b0;
                        o_DONE <= 1'b1;
                    end
                S_ADDR_PRE, S_GAP:
                    if (tmr_done)
                    begin
                        o_SENSE <= 4'h0;
                        o_PULSE <= bit_mask;
                        pulses_r <= pulses_r + 16'h0001;
                        tmr_load_r <= 1'b1;
                        tmr_count_r <= PULSE_32[`CNT_W-1:0];
                    end
                S_PULSE:
                    if (tmr_done)
                    begin
                        o_PULSE <= 4'h0;
                        tmr_load_r <= 1'b1;
                        tmr_count_r <= SDLY_32[`CNT_W-1:0];
                    end
                S_DELAY:
                    if (tmr_done)
                    begin
                        tmr_load_r <= 1'b1;
                        if (extra_mode_r)
                        begin
                            if (extra_r == 3'h1)
                            begin
                                // All extra pulses given: guard before address may move
                                state_r <= S_POST;
                                tmr_count_r <= GUARD_32[`CNT_W-1:0];
                            end
                            else
                                tmr_count_r <= GAP_32[`CNT_W-1:0];
                            extra_r <= extra_r - 3'h1;
                        end
                        else
                        begin
                            o_SENSE <= bit_mask;
                            tmr_count_r <= SETTLE_32[`CNT_W-1:0];
                        end
                    end
                S_SENSE:
                    if (tmr_done)
                    begin
                        o_SENSE <= 4'h0;
                        tmr_load_r <= 1'b1;
                        if (sense_hi_r)
                        begin
                            extra_mode_r <= 1'b1;
                            extra_r <= s_series_r ? EXTRA_S_32[2:0] : EXTRA_N_32[2:0];
                            tmr_count_r <= GAP_32[`CNT_W-1:0];
                        end
                        else if (pulses_r >= limit_r)
                        begin
                            o_FAIL <= 1'b1;
                            state_r <= S_POST;
                            tmr_count_r <= GUARD_32[`CNT_W-1:0];
                        end
                        else
                            tmr_count_r <= GAP_32[`CNT_W-1:0];
                    end
                S_POST:
                    if (tmr_done)
                    begin
                        o_BUSY <= 1'b0;
                        o_DONE <= 1'b1;
                    end
                default:
                    o_PULSE <= 4'h0;
            endcase
            if (!((state_r == S_DELAY && extra_mode_r && extra_r == 3'h1 && tmr_done)
                || (state_r == S_SENSE && tmr_done && !sense_hi_r && pulses_r >= limit_r)))
                state_r <= state_nxt;
        end
    end
endmodule // prom_prog_ctrl

/* tb/prom_prog_ctrl_asserts.sv */
/*
 Pin checker for the fuse PROM controller.
 Assumes it is bound into prom_prog_ctrl, one clock.
*/
`timescale 1ns/1ns
`include "prom_prog_regs.vh"
module prom_prog_ctrl_asserts
(
    // Watched ports
    input wire I_SYS_CLK,
    input wire I_SYS_RST,
    input wire [`ADDR_W-1:0] o_PROM_ADDR,
    input wire o_PROM_CE_N,
    input wire [`DATA_W-1:0] o_PULSE,
    input wire [`DATA_W-1:0] o_SENSE
);
    // ----------
    // Gap counters
    // ----------
    // Saturating, so a long idle never wraps into a false failure
    reg [15:0] pulse_gap_r;
    reg [15:0] sense_gap_r;
    reg [15:0] addr_age_r;
    reg [`ADDR_W-1:0] addr_prev_r;
    wire addr_moved = o_PROM_ADDR != addr_prev_r;
    function [15:0] inc(input [15:0] v);
        inc = &v ? v : v + 16'h0001;
    endfunction
    always @(posedge I_SYS_CLK)
    begin
        addr_prev_r <= o_PROM_ADDR;
        pulse_gap_r <= I_SYS_RST ? 16'hFFFF : |o_PULSE ? 16'h0000 : inc(pulse_gap_r);
        sense_gap_r <= I_SYS_RST ? 16'hFFFF : |o_SENSE ? 16'h0000 : inc(sense_gap_r);
        addr_age_r <= I_SYS_RST ? 16'hFFFF : addr_moved ? 16'h0001 : inc(addr_age_r);
    end
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    chk_ce_pulse: assert property (|o_PULSE |-> o_PROM_CE_N)
        else $error("pulse with chip enabled");
    chk_ce_sense: assert property (|o_SENSE |-> o_PROM_CE_N)
        else $error("sense with chip enabled");
    chk_one_pulse: assert property ($onehot0(o_PULSE))
        else $error("several outputs pulsed");
    chk_one_sense: assert property ($onehot0(o_SENSE) && !(|o_PULSE && |o_SENSE))
        else $error("sense not single or overlaps pulse");
    chk_addr_hold: assert property (|o_PULSE |-> $stable(o_PROM_ADDR))
        else $error("address moved under pulse");
    chk_sense_delay: assert property ($rose(|o_SENSE) |-> pulse_gap_r >= `SENSE_DLY_CYC)
        else $error("sense too soon after pulse");
    chk_guard_before: assert property (addr_moved |-> sense_gap_r >= `ADDR_GUARD_CYC)
        else $error("address moved too soon after sense");
    chk_guard_after: assert property (|o_SENSE |-> addr_age_r >= `ADDR_GUARD_CYC)
        else $error("sense too soon after address move");
endmodule // prom_prog_ctrl_asserts
bind prom_prog_ctrl prom_prog_ctrl_asserts u_chk
(
    .I_SYS_CLK(I_SYS_CLK),
    .I_SYS_RST(I_SYS_RST),
    .o_PROM_ADDR(o_PROM_ADDR),
    .o_PROM_CE_N(o_PROM_CE_N),
    .o_PULSE(o_PULSE),
    .o_SENSE(o_SENSE)
);

/* tb/prom_dev_model.sv */
/*
 Behavioural 2048 x 4 fuse PROM on the controller's pins.
 Assumes pins change on the bench clock; a fuse opens after i_need pulses.
*/
`timescale 1ns/1ns
module prom_dev_model
(
    // Bench control
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic [15:0] i_need,
    // Device pins
    input wire logic [10:0] i_addr,
    input wire logic i_ce_n,
    input wire logic [3:0] i_pulse,
    input wire logic [3:0] i_sense,
    output logic [3:0] o_data,
    output logic o_sense_hi,
    output logic [15:0] o_pulse_cnt
);
    // ----------
    // Fuse array
    // ----------
    logic [3:0] mem [0:2047];
    logic [3:0] last_r = 4'h0;
    logic [3:0] prev_r = 4'h0;
    initial
        for (int i = 0; i < 2048; i++)
            mem[i] = 4'h0;
    // Released pins show the inverse of the last word, never a stale match
    assign o_data = i_ce_n ? ~last_r : mem[i_addr];
    assign o_sense_hi = i_ce_n & |(i_sense & mem[i_addr]);
    always @(posedge i_clk)
    begin
        prev_r <= i_pulse;
        if (!i_ce_n)
            last_r <= mem[i_addr];
        if (i_clr)
            o_pulse_cnt <= 16'h0000;
        else if (i_pulse != 4'h0 && prev_r == 4'h0)
        begin
            o_pulse_cnt <= o_pulse_cnt + 16'h0001;
            // Only a lone pulse on a deselected chip opens a fuse
            if (i_ce_n && $onehot(i_pulse) && o_pulse_cnt + 16'h0001 >= i_need)
                mem[i_addr] <= mem[i_addr] | i_pulse;
        end
    end
endmodule // prom_dev_model

/* tb/tb_top.sv */
/*
 Self-checking bench: controller against the fuse PROM model.
 Assumes the controller header and a 250 MHz clock.
*/
`timescale 1ns/1ns
`include "prom_prog_regs.vh"
module tb_top;
    // ----------
    // Stimulus
    // ----------
    logic clk = 1'b0, rst = 1'b1, rd_req = 1'b0, pg_req = 1'b0, s_ser = 1'b0, clr = 1'b0;
    logic [10:0] addr = 11'h000;
    logic [1:0] bsel = 2'h0;
    logic [15:0] maxn = 16'h0008, need = 16'h0001;
    logic busy, done, fail, ce_n, sense_hi;
    logic [3:0] rd_data, prom_data, pulse, sense;
    logic [10:0] prom_addr;
    logic [15:0] pulse_cnt;
    logic [3:0] shadow [0:2047];
    logic [31:0] seed = 32'h50D3;
    int err_count = 0;
    int n_checks = 0;
    initial
        forever #2 clk = ~clk;
    prom_prog_ctrl u_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .i_READ_REQ(rd_req),
        .i_PROG_REQ(pg_req), .i_S_SERIES(s_ser), .i_ADDR(addr), .i_BIT_SEL(bsel),
        .i_MAX_PULSES_N(maxn), .o_BUSY(busy), .o_DONE(done), .o_FAIL(fail),
        .o_RD_DATA(rd_data), .o_PROM_ADDR(prom_addr), .o_PROM_CE_N(ce_n),
        .i_PROM_DATA(prom_data), .o_PULSE(pulse), .o_SENSE(sense), .I_SENSE_HI(sense_hi));
    prom_dev_model u_prom (.i_clk(clk), .i_clr(clr), .i_need(need), .i_addr(prom_addr),
        .i_ce_n(ce_n), .i_pulse(pulse), .i_sense(sense), .o_data(prom_data),
        .o_sense_hi(sense_hi), .o_pulse_cnt(pulse_cnt));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic run_op(input logic prog);
        int n;
        @(posedge clk);
        rd_req <= ~prog;
        pg_req <= prog;
        clr <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        pg_req <= 1'b0;
        clr <= 1'b0;
        for (n = 0; n < 40000; n++)
        begin
            @(posedge clk);
            #1;
            if (done === 1'b1)
                break;
        end
        if (n == 40000)
        begin
            err_count++;
            $display("MISMATCH t=%0t no completion", $time);
            stop_test();
        end
        check({14'h0000, busy, ce_n}, 16'h0001);
    endtask
    task automatic read_word(input logic [10:0] a);
        @(posedge clk);
        addr <= a;
        run_op(1'b0);
        check({12'h000, rd_data}, {12'h000, shadow[a]});
    endtask
    task automatic prog_case(input logic [10:0] a, input logic [1:0] b, input logic s,
                             input logic [15:0] nd, input logic [15:0] mx);
        logic [15:0] lim;
        lim = s ? `MAX_PULSES_S : mx;
        @(posedge clk);
        addr <= a;
        bsel <= b;
        s_ser <= s;
        need <= nd;
        maxn <= mx;
        run_op(1'b1);
        check(pulse_cnt, (nd > lim) ? lim : nd + (s ? `EXTRA_S : `EXTRA_N));
        check({15'h0000, fail}, {15'h0000, nd > lim});
        if (nd <= lim)
            shadow[a] = shadow[a] | (4'h1 << b);
        read_word(a);
        $display("program test done");
    endtask
    initial
    begin
        for (int i = 0; i < 2048; i++)
            shadow[i] = 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4)
        begin
            seed = xs(seed);
            read_word(seed[10:0]);
        end
        $display("blank read test done");
        seed = xs(seed);
        // Same word twice: the second bit must not clear the first
        prog_case(11'h000, seed[1:0], 1'b0, 16'h0002, 16'h0008);
        prog_case(11'h000, seed[1:0] ^ 2'h1, 1'b1, 16'h0001, 16'h0008);
        prog_case(11'h7FF, seed[3:2], 1'b0, 16'h0063, 16'h0003);
        stop_test();
    end
endmodule // tb_top
